// file: hw/pal_defs.svh
// Offsets, field positions, reset values and timing figures of the
// auxiliary/indicator/page register group. Definitions only.
`ifndef PAL_DEFS_SVH
`define PAL_DEFS_SVH
// ==========================================================
// Register offsets
`define PAL_ADDR_CRC      5'h12
`define PAL_ADDR_EXT      5'h13
`define PAL_ADDR_AUX      5'h1c
`define PAL_ADDR_LEDM     5'h1d
`define PAL_ADDR_LEDB     5'h1e
`define PAL_ADDR_PAGE     5'h1f
`define PAL_ADDR_PAGED    5'h10
// ==========================================================
// Page codes
`define PAL_PG_MAIN       16'h0000
`define PAL_PG_EXT1       16'h0001
`define PAL_PG_EXT2       16'h0002
`define PAL_PG_EXT3       16'h0003
`define PAL_PG_GPIO       16'h0010
// ==========================================================
// Field positions
`define PAL_AUX_TMO_HI    7
`define PAL_AUX_SLEEP     6
`define PAL_AUX_TMO_LO    2
`define PAL_LB_RSV_LO     14
`define PAL_LB_PULSE      12
`define PAL_LB_RATE_LO    10
`define PAL_LB_SEL_LO     5
`define PAL_EM_LEDX_LO    12
`define PAL_EM_RBLINK     11
`define PAL_EM_FLL        4
`define PAL_EM_XO_LO      2
`define PAL_CRC_SEEN      15
// ==========================================================
// Reset values
`define PAL_LEDM_RST      16'h8021
`define PAL_TMO_RST       2'h1
`define PAL_RATE_RST      2'h1
`define PAL_XO_RSV        2'h1
`define PAL_CRC_LAST      14'h270f
// ==========================================================
// Timing
`define PAL_CLK_NS        10
`define PAL_CLK_HZ        100000000
`define PAL_TICK_NS       25000000
`define PAL_PULSE_HZ      5000
`define PAL_TMO_BASE_MS   2300
`define PAL_TMO_STEP_MS   1000
`define PAL_STRETCH_TICKS 5'h10
`define PAL_RB_TICKS      5'h10
`endif

// file: hw/pal_pkg.sv
// Types shared by the register group: register targets.
// Assumes pal_defs.svh for numeric constants.
package pal_pkg;
  typedef logic [4:0]  pal_addr_t;
  typedef logic [15:0] pal_word_t;
  typedef enum logic [2:0] {
    PAL_T_NONE = 3'b000,
    PAL_T_AUX  = 3'b001,
    PAL_T_LEDM = 3'b010,
    PAL_T_LEDB = 3'b011,
    PAL_T_PAGE = 3'b100,
    PAL_T_CRC  = 3'b101,
    PAL_T_EXT  = 3'b110
  } pal_tgt_t;
endpackage

// file: hw/pal_regs.sv
// Auxiliary status, indicator control, page select and good-CRC
// counter registers of one copper transceiver port.
// Assumes status inputs come from logic on core_clk; only the
// low-power hold pin is asynchronous.
//
// Contract
// - Bit 15: negotiation complete, else link status
// - Bit 14 is inverted negotiation enable
// - Crossover, pair swap, polarity read-only indications
// - Sleep timeout from bits 7 and 2
// - Speed code in bits 4:3
// - Bit 5 shows full duplex
// - Media selection two-bit read-only field
// - Four sticky indicator mode fields, given defaults
// - Pulsing enable gives 5 kHz pulse train
// - Rate field selects blink and stretch time
// - Only first port rate field is used
// - Per-indicator stretch or blink select
// - Combine-disable for indicators 0 and 1
// - Page register selects register space
// - Registers 0-15 never redirected by page
// - Packet-seen bit set, cleared on read
// - 14-bit good-CRC count modulo 10000, read-clear
// - Reset-blink bit controls blink after hold release
// - Fast link failure enable, first port only
// - Crossover force field decode
// - Sticky fields kept through soft reset if enabled
`timescale 1ns/10ps
`include "pal_defs.svh"

module pal_regs #(
  parameter int TICK_CYC  = `PAL_TICK_NS / `PAL_CLK_NS,
  parameter int PULSE_CYC = `PAL_CLK_HZ / `PAL_PULSE_HZ
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             clk_en,
  input  wire pal_pkg::pal_addr_t reg_addr,
  input  wire pal_pkg::pal_word_t reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output      pal_pkg::pal_word_t reg_rdata,
  input  wire logic             an_enable,
  input  wire logic             an_complete,
  input  wire logic             link_up,
  input  wire logic             xover_done,
  input  wire logic             pair_three_four_swap,
  input  wire logic [3:0]       pol_inv,
  input  wire logic             duplex_indication,
  input  wire logic [1:0]       speed_code,
  input  wire logic [1:0]       media_sel,
  input  wire logic             good_crc_pkt,
  input  wire logic             soft_reset,
  input  wire logic             sticky_keep,
  input  wire logic             first_port,
  input  wire logic [1:0]       global_rate,
  input  wire logic [6:0]       pulse_duty,
  input  wire logic [3:0]       led_on,
  input  wire logic [3:0]       led_act,
  input  wire logic             low_power_hold_input,
  output      logic             indicator_out_0,
  output      logic             indicator_out_1,
  output      logic             indicator_out_2,
  output      logic             indicator_out_3,
  output      logic [1:0]       rate_out,
  output      logic [3:0]       led_ext_mode,
  output      logic             fll_pin_en,
  output      logic [1:0]       xover_force,
  output      logic             sleep_en,
  output      logic [12:0]      sleep_timeout_ms
);
  import pal_pkg::*;

  localparam int TW = $clog2(TICK_CYC);
  localparam int PW = $clog2(PULSE_CYC);
  localparam int DUTY_STEP = PULSE_CYC / 100;

  // ==========================================================
  // Address decode
  // Registers 0-15 live outside this group and are never paged;
  // the GPIO page takes 16-30, so nothing here answers there.
  function automatic pal_tgt_t tgt_of(pal_addr_t a, pal_word_t pg);
    tgt_of = PAL_T_NONE;
    if (a == `PAL_ADDR_PAGE) begin
      tgt_of = PAL_T_PAGE;
    end else if (a >= `PAL_ADDR_PAGED) begin
      if (pg == `PAL_PG_MAIN) begin
        if (a == `PAL_ADDR_AUX)  tgt_of = PAL_T_AUX;
        if (a == `PAL_ADDR_LEDM) tgt_of = PAL_T_LEDM;
        if (a == `PAL_ADDR_LEDB) tgt_of = PAL_T_LEDB;
      end else if (pg == `PAL_PG_EXT1) begin
        if (a == `PAL_ADDR_CRC) tgt_of = PAL_T_CRC;
        if (a == `PAL_ADDR_EXT) tgt_of = PAL_T_EXT;
      end
    end
  endfunction

  logic [1:0]  tmo_reg;
  logic        sleep_reg;
  logic [15:0] ledm_reg;
  logic [1:0]  lb_rsv_reg;
  logic        pulse_reg;
  logic [1:0]  rate_reg;
  logic [3:0]  ssel_reg;
  logic [1:0]  comb_dis_reg;
  logic [3:0]  ledx_reg;
  logic        rblink_reg;
  logic        fll_reg;
  logic [1:0]  xo_reg;
  logic        em_rsv_reg;
  logic [15:0] page_reg;
  logic [13:0] crc_cnt_reg;
  logic        crc_seen_reg;
  logic [15:0] rdata_reg;
  logic [12:0] tmo_ms_reg;
  logic [3:0]  ind_reg;

  pal_tgt_t tgt;
  logic     sreset;
  logic     crc_rd;

  assign tgt    = tgt_of(reg_addr, page_reg);
  assign sreset = clk_en & soft_reset & ~sticky_keep;
  assign crc_rd = clk_en & reg_rd & (tgt == PAL_T_CRC);

  // ==========================================================
  // Writable fields
  // A soft reset in the same cycle as a write wins over the write.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tmo_reg   <= `PAL_TMO_RST;
      sleep_reg <= 1'b0;
    end else if (sreset) begin
      tmo_reg   <= `PAL_TMO_RST;
      sleep_reg <= 1'b0;
    end else if (clk_en && reg_wr && tgt == PAL_T_AUX) begin
      tmo_reg   <= {reg_wdata[`PAL_AUX_TMO_HI], reg_wdata[`PAL_AUX_TMO_LO]};
      sleep_reg <= reg_wdata[`PAL_AUX_SLEEP];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ledm_reg <= `PAL_LEDM_RST;
    end else if (sreset) begin
      ledm_reg <= `PAL_LEDM_RST;
    end else if (clk_en && reg_wr && tgt == PAL_T_LEDM) begin
      ledm_reg <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_reg    <= 1'b0;
      rate_reg     <= `PAL_RATE_RST;
      ssel_reg     <= 4'h0;
      comb_dis_reg <= 2'h0;
    end else if (sreset) begin
      pulse_reg    <= 1'b0;
      rate_reg     <= `PAL_RATE_RST;
      ssel_reg     <= 4'h0;
      comb_dis_reg <= 2'h0;
    end else if (clk_en && reg_wr && tgt == PAL_T_LEDB) begin
      pulse_reg    <= reg_wdata[`PAL_LB_PULSE];
      rate_reg     <= reg_wdata[`PAL_LB_RATE_LO +: 2];
      ssel_reg     <= reg_wdata[`PAL_LB_SEL_LO +: 4];
      comb_dis_reg <= reg_wdata[1:0];
    end
  end

  // Reserved read/write bits are always sticky: only a hard reset clears
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lb_rsv_reg <= 2'h0;
      em_rsv_reg <= 1'b0;
    end else if (clk_en && reg_wr) begin
      if (tgt == PAL_T_LEDB) lb_rsv_reg <= reg_wdata[`PAL_LB_RSV_LO +: 2];
      if (tgt == PAL_T_EXT)  em_rsv_reg <= reg_wdata[0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ledx_reg   <= 4'h0;
      rblink_reg <= 1'b0;
      fll_reg    <= 1'b0;
      xo_reg     <= 2'h0;
    end else if (sreset) begin
      ledx_reg   <= 4'h0;
      rblink_reg <= 1'b0;
      fll_reg    <= 1'b0;
      xo_reg     <= 2'h0;
    end else if (clk_en && reg_wr && tgt == PAL_T_EXT) begin
      ledx_reg   <= reg_wdata[`PAL_EM_LEDX_LO +: 4];
      rblink_reg <= reg_wdata[`PAL_EM_RBLINK];
      xo_reg     <= reg_wdata[`PAL_EM_XO_LO +: 2];
      if (first_port) begin
        fll_reg <= reg_wdata[`PAL_EM_FLL];
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      page_reg <= `PAL_PG_MAIN;
    end else if (clk_en && reg_wr && tgt == PAL_T_PAGE) begin
      page_reg <= reg_wdata;
    end
  end

  // ==========================================================
  // Good-CRC counter
  // A packet in the cycle of the clearing read is counted afresh,
  // so it is never lost.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      crc_cnt_reg  <= 14'h0000;
      crc_seen_reg <= 1'b0;
    end else if (clk_en) begin
      if (good_crc_pkt) begin
        crc_seen_reg <= 1'b1;
        if (crc_rd || crc_cnt_reg == `PAL_CRC_LAST) begin
          crc_cnt_reg <= crc_rd ? 14'h0001 : 14'h0000;
        end else begin
          crc_cnt_reg <= crc_cnt_reg + 14'h0001;
        end
      end else if (crc_rd) begin
        crc_seen_reg <= 1'b0;
        crc_cnt_reg  <= 14'h0000;
      end
    end
  end

  // ==========================================================
  // Read path
  pal_word_t rd_word;
  always_comb begin
    rd_word = 16'h0000;
    unique case (tgt)
      PAL_T_NONE: rd_word = 16'h0000;
      PAL_T_AUX: begin
        rd_word[15] = an_enable ? an_complete : link_up;
        rd_word[14] = ~an_enable;
        rd_word[13] = xover_done;
        rd_word[12] = pair_three_four_swap;
        rd_word[11:8] = {pol_inv[0], pol_inv[1], pol_inv[2], pol_inv[3]};
        rd_word[`PAL_AUX_TMO_HI] = tmo_reg[1];
        rd_word[`PAL_AUX_SLEEP] = sleep_reg;
        rd_word[5] = duplex_indication;
        rd_word[4:3] = speed_code;
        rd_word[`PAL_AUX_TMO_LO] = tmo_reg[0];
        rd_word[1:0] = media_sel;
      end
      PAL_T_LEDM: rd_word = ledm_reg;
      PAL_T_LEDB: begin
        rd_word[`PAL_LB_RSV_LO +: 2] = lb_rsv_reg;
        rd_word[`PAL_LB_PULSE] = pulse_reg;
        rd_word[`PAL_LB_RATE_LO +: 2] = rate_reg;
        rd_word[`PAL_LB_SEL_LO +: 4] = ssel_reg;
        rd_word[1:0] = comb_dis_reg;
      end
      PAL_T_PAGE: rd_word = page_reg;
      PAL_T_CRC: rd_word = {crc_seen_reg, 1'b0, crc_cnt_reg};
      PAL_T_EXT: begin
        rd_word[`PAL_EM_LEDX_LO +: 4] = ledx_reg;
        rd_word[`PAL_EM_RBLINK] = rblink_reg;
        rd_word[`PAL_EM_FLL] = fll_reg;
        rd_word[`PAL_EM_XO_LO +: 2] = xo_reg;
        rd_word[0] = em_rsv_reg;
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 16'h0000;
    end else if (clk_en) begin
      rdata_reg <= reg_rd ? rd_word : 16'h0000;
    end
  end
  assign reg_rdata = rdata_reg;

  // ==========================================================
  // Control outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tmo_ms_reg <= 13'h0000;
    end else if (clk_en) begin
      tmo_ms_reg <= 13'(`PAL_TMO_BASE_MS + `PAL_TMO_STEP_MS * int'(tmo_reg));
    end
  end
  assign sleep_timeout_ms = tmo_ms_reg;
  assign sleep_en         = sleep_reg;
  assign led_ext_mode     = ledx_reg;
  assign fll_pin_en       = fll_reg;
  // Reserved code 01 falls back to automatic crossover
  assign xover_force      = (xo_reg == `PAL_XO_RSV) ? 2'h0 : xo_reg;
  assign rate_out         = rate_reg;

  // ==========================================================
  // Indicator timing
  logic [1:0]    rate_use;
  logic [TW-1:0] tcnt_reg;
  logic          tick;
  logic [3:0]    bcnt_reg;
  logic          blink_ph;
  logic [PW-1:0] pcnt_reg;
  logic          pulse_on;
  assign rate_use = first_port ? rate_reg : global_rate;
  assign tick     = clk_en && (tcnt_reg == TW'(TICK_CYC - 1));
  assign blink_ph = bcnt_reg[2'd3 - rate_use];
  assign pulse_on = int'(pcnt_reg) < int'(pulse_duty) * DUTY_STEP;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tcnt_reg <= '0;
      bcnt_reg <= 4'h0;
    end else if (clk_en) begin
      tcnt_reg <= tick ? '0 : tcnt_reg + TW'(1);
      if (tick) bcnt_reg <= bcnt_reg + 4'h1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pcnt_reg <= '0;
    end else if (clk_en) begin
      pcnt_reg <= (pcnt_reg == PW'(PULSE_CYC - 1)) ? '0 : pcnt_reg + PW'(1);
    end
  end

  // Low-power hold pin: two-flop synchroniser, edge taken on stage 2
  logic       lph_s1, lph_s2, lph_s3;
  logic [4:0] rb_cnt_reg;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      lph_s1 <= 1'b0;
      lph_s2 <= 1'b0;
      lph_s3 <= 1'b0;
    end else if (clk_en) begin
      lph_s1 <= low_power_hold_input;
      lph_s2 <= lph_s1;
      lph_s3 <= lph_s2;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rb_cnt_reg <= 5'h00;
    end else if (clk_en) begin
      if (lph_s3 && !lph_s2 && rblink_reg) begin
        rb_cnt_reg <= `PAL_RB_TICKS;
      end else if (tick && rb_cnt_reg != 5'h00) begin
        rb_cnt_reg <= rb_cnt_reg - 5'h01;
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ind
      logic [4:0] scnt_reg;
      logic       act;
      logic       lit;
      // Combine-disable only exists on indicators 0 and 1
      if (gi < 2) begin : g_comb
        assign act = led_act[gi] & ~comb_dis_reg[gi];
      end else begin : g_plain
        assign act = led_act[gi];
      end
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          scnt_reg <= 5'h00;
        end else if (clk_en) begin
          if (act) begin
            scnt_reg <= `PAL_STRETCH_TICKS >> rate_use;
          end else if (tick && scnt_reg != 5'h00) begin
            scnt_reg <= scnt_reg - 5'h01;
          end
        end
      end
      always_comb begin
        if (rb_cnt_reg != 5'h00) begin
          lit = blink_ph;
        end else if (ssel_reg[gi]) begin
          lit = led_on[gi] | (scnt_reg != 5'h00);
        end else begin
          lit = act ? blink_ph : led_on[gi];
        end
      end
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          ind_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          ind_reg[gi] <= lit & (~pulse_reg | pulse_on);
        end
      end
    end
  endgenerate

  assign indicator_out_0 = ind_reg[0];
  assign indicator_out_1 = ind_reg[1];
  assign indicator_out_2 = ind_reg[2];
  assign indicator_out_3 = ind_reg[3];

  // ==========================================================
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);

  a_aux_link_copy: assert property (
    clk_en && reg_rd && tgt == PAL_T_AUX
    |=> reg_rdata[15] == ($past(an_enable) ? $past(an_complete) : $past(link_up)))
    else $error("aux bit 15 wrong");
  a_aux_an_inv: assert property (
    clk_en && reg_rd && tgt == PAL_T_AUX |=> reg_rdata[14] != $past(an_enable))
    else $error("aux bit 14 not inverted");
  a_aux_speed: assert property (
    clk_en && reg_rd && tgt == PAL_T_AUX |=> reg_rdata[4:3] == $past(speed_code))
    else $error("speed field wrong");
  a_low_unpaged: assert property (
    clk_en && reg_rd && reg_addr < `PAL_ADDR_PAGED |=> reg_rdata == 16'h0000)
    else $error("low register answered");
  a_crc_wrap: assert property (
    clk_en && good_crc_pkt && !crc_rd && crc_cnt_reg == `PAL_CRC_LAST
    |=> crc_cnt_reg == 14'h0000)
    else $error("counter did not wrap");
  a_crc_seen: assert property (
    clk_en && good_crc_pkt |=> crc_seen_reg ##1 (crc_seen_reg || $past(crc_rd)))
    else $error("packet flag lost");
  a_fll_port: assert property (
    !first_port && !sreset |=> $stable(fll_reg))
    else $error("fll changed from other port");
  a_sticky_rst: assert property (
    sreset |=> ledm_reg == `PAL_LEDM_RST && tmo_reg == `PAL_TMO_RST)
    else $error("sticky fields not defaulted");
  a_xo_reserved: assert property (
    xo_reg == `PAL_XO_RSV |-> xover_force == 2'h0)
    else $error("reserved crossover code forced");
  a_pulse_gate: assert property (
    clk_en && pulse_reg && !pulse_on |=> ind_reg == 4'h0)
    else $error("indicator lit outside pulse");

endmodule

// file: dv/pal_regs_tb_top.sv
// Self-checking bench for the auxiliary/indicator/page register group.
// Assumes one core clock, the register port of pal_regs and short tick
// parameters so that indicator timing stays within a short run.
`timescale 1ns/10ps
`include "pal_defs.svh"

module pal_regs_tb_top;
  import pal_pkg::*;
  // ==========================================================
  // Signals
  logic      core_clk, resetn, clk_en, reg_wr, reg_rd;
  pal_addr_t reg_addr;
  pal_word_t reg_wdata, reg_rdata, v, d;
  logic      an_enable, an_complete, link_up, xover_done, pair_three_four_swap;
  logic      duplex_indication, good_crc_pkt, soft_reset, sticky_keep, first_port;
  logic      low_power_hold_input, fll_pin_en, sleep_en;
  logic      indicator_out_0, indicator_out_1, indicator_out_2, indicator_out_3;
  logic [3:0]  pol_inv, led_on, led_act, led_ext_mode;
  logic [1:0]  speed_code, media_sel, global_rate, rate_out, xover_force;
  logic [6:0]  pulse_duty;
  logic [12:0] sleep_timeout_ms;
  logic [7:0]  aux_ctl;
  logic [3:0]  ind;
  int          n_errors, checks, seed, n;

  pal_regs #(.TICK_CYC(8), .PULSE_CYC(200)) i_dut (.*);
  assign ind = {indicator_out_3, indicator_out_2, indicator_out_1, indicator_out_0};

  always #5 core_clk = ~core_clk;
  // ==========================================================
  // Compare, bus and verdict tasks
  task automatic chk(input pal_word_t s, input pal_word_t e);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic wr(input pal_addr_t a, input pal_word_t w);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= w;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe is taken
  task automatic rd(input pal_addr_t a, output pal_word_t r);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
  endtask

  task automatic conclude;
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic pulse_pkts(input int k);
    repeat (k) begin
      @(posedge core_clk) good_crc_pkt <= 1'b1;
      @(posedge core_clk) good_crc_pkt <= 1'b0;
    end
  endtask

  task automatic soft_rst(input logic keep);
    @(posedge core_clk);
    sticky_keep <= keep; soft_reset <= 1'b1;
    @(posedge core_clk) soft_reset <= 1'b0;
  endtask

  // Cycles in which indicator k is lit over the next w clock edges
  task automatic lit_cnt(input int k, input int w, output int c);
    c = 0;
    repeat (w) begin
      @(posedge core_clk);
      #1 c += int'(ind[k]);
    end
  endtask

  // Expected auxiliary status word from the bench's own copy of inputs
  function automatic pal_word_t aux_exp();
    return {an_enable ? an_complete : link_up, ~an_enable, xover_done,
            pair_three_four_swap, pol_inv[0], pol_inv[1], pol_inv[2], pol_inv[3],
            aux_ctl[7:6], duplex_indication, speed_code, aux_ctl[2], media_sel};
  endfunction

  initial begin
    repeat (100000) @(posedge core_clk);
    n_errors++;
    conclude();
  end
  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'h9a57;
    {core_clk, resetn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {an_enable, an_complete, link_up, xover_done, pair_three_four_swap} = '0;
    {pol_inv, duplex_indication, speed_code, media_sel, good_crc_pkt} = '0;
    {soft_reset, sticky_keep, first_port, global_rate, low_power_hold_input} = '0;
    {led_on, led_act} = '0;
    clk_en = 1'b1;
    pulse_duty = 7'd50;
    aux_ctl = 8'h04;
    n_errors = 0; checks = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    rd(5'h1d, v); chk(v, 16'h8021);
    rd(5'h1e, v); chk(v, 16'h0400);
    rd(5'h1f, v); chk(v, 16'h0000);
    chk({3'b0, sleep_timeout_ms}, 16'd3300);
    for (int i = 0; i < 24; i++) begin
      @(posedge core_clk);
      {an_enable, an_complete, link_up, xover_done} <= 4'($random(seed));
      {pair_three_four_swap, pol_inv, duplex_indication} <= 6'($random(seed));
      speed_code <= 2'($unsigned($random(seed)) % 3);
      media_sel <= 2'($random(seed) & 1);
      {global_rate, led_on} <= 6'($random(seed));
      @(posedge core_clk);
      rd(5'h1c, v); chk(v, aux_exp());
    end
    // Timeout codes, bit 7 the upper half of the code
    for (int c = 0; c < 4; c++) begin
      aux_ctl = {c[1], c[0], 3'b0, c[0], 2'b0};
      wr(5'h1c, {8'hff, aux_ctl} | 16'h003b);
      repeat (2) @(posedge core_clk);
      #1 chk({3'b0, sleep_timeout_ms}, 16'(2300 + 1000 * c));
      chk({15'b0, sleep_en}, {15'b0, c[0]});
      rd(5'h1c, v); chk(v, aux_exp());
    end
    wr(5'h1f, 16'h0001);
    rd(5'h1c, v); chk(v, 16'h0000);
    rd(5'h05, v); chk(v, 16'h0000);
    @(posedge core_clk) first_port <= 1'b0;
    wr(5'h13, 16'h0010);
    repeat (2) @(posedge core_clk);
    #1 chk({15'b0, fll_pin_en}, 16'h0000);
    @(posedge core_clk) first_port <= 1'b1;
    for (int x = 0; x < 4; x++) begin
      wr(5'h13, 16'hfff3 | 16'(x << 2));
      rd(5'h13, v); chk(v, 16'hf811 | 16'(x << 2));
      chk({14'b0, xover_force}, (x == 1) ? 16'h0 : 16'(x));
      chk({11'b0, fll_pin_en, led_ext_mode}, 16'h001f);
    end
    // Packet counter: plain count, then across the wrap
    n = 1 + ($unsigned($random(seed)) % 40);
    pulse_pkts(n);
    rd(5'h12, v); chk(v, 16'h8000 | 16'(n));
    rd(5'h12, v); chk(v, 16'h0000);
    pulse_pkts(10001);
    rd(5'h12, v); chk(v, 16'h8001);
    wr(5'h1f, 16'h0002);
    rd(5'h1d, v); chk(v, 16'h0000);
    wr(5'h1f, 16'h0010);
    rd(5'h1e, v); chk(v, 16'h0000);
    wr(5'h1f, 16'h0000);
    wr(5'h1e, 16'hffff);
    rd(5'h1e, v); chk(v, 16'hdde3);
    chk({14'b0, rate_out}, 16'h0003);
    // Sticky fields through a software reset
    d = 16'($random(seed));
    wr(5'h1d, d);
    soft_rst(1'b1);
    rd(5'h1d, v); chk(v, d);
    soft_rst(1'b0);
    rd(5'h1d, v); chk(v, 16'h8021);
    rd(5'h1e, v); chk(v, 16'hc400);
    // Indicators 0/1 stretched at the global rate, combine off on 0
    @(posedge core_clk) {first_port, global_rate, led_on} <= 7'h00;
    wr(5'h1e, 16'h0461);
    @(posedge core_clk) led_act <= 4'h3;
    @(posedge core_clk) led_act <= 4'h0;
    lit_cnt(0, 16, n); chk(16'(n), 16'h0000);
    lit_cnt(1, 24, n); chk(16'(n), 16'h0018);
    // Own rate would end the stretch after 8 ticks, the global one after 16
    repeat (32) @(posedge core_clk);
    lit_cnt(1, 40, n); chk(16'(n), 16'h0028);
    repeat (16) @(posedge core_clk);
    lit_cnt(1, 16, n); chk(16'(n), 16'h0000);
    // Pulse train: duty in percent of one 200-cycle pulse period
    @(posedge core_clk) led_on <= 4'hf;
    pulse_duty <= 7'($unsigned($random(seed)) % 101);
    wr(5'h1e, 16'h1400);
    repeat (2) @(posedge core_clk);
    lit_cnt(2, 200, n); chk(16'(n), 16'(200 * pulse_duty / 100));
    // Blink after the hold pin is released, only when enabled
    wr(5'h1e, 16'h0400);
    @(posedge core_clk) led_on <= 4'h0;
    wr(5'h1f, 16'h0001);
    for (int b = 0; b < 2; b++) begin
      wr(5'h13, 16'(b << 11));
      @(posedge core_clk) low_power_hold_input <= 1'b1;
      repeat (4) @(posedge core_clk);
      low_power_hold_input <= 1'b0;
      lit_cnt(3, 160, n); chk(16'(n != 0), 16'(b));
    end
    // A strobe while the clock enable is low is not taken
    @(posedge core_clk) clk_en <= 1'b0;
    wr(5'h1f, 16'h0003);
    @(posedge core_clk) clk_en <= 1'b1;
    rd(5'h1f, v); chk(v, 16'h0001);
    conclude();
  end
endmodule
